/* inc/mvw_pkg.sv */
`default_nettype none
package mvw_pkg;
  // Register indices as printed; byte address is four times the index.
  localparam logic [7:0] IDX_PAUSE_CONTROL = 8'h06;
  localparam logic [7:0] IDX_TAG_MATCH_A = 8'h09;
  localparam logic [7:0] IDX_TAG_MATCH_B = 8'h0a;
  localparam logic [7:0] IDX_WAKE_PATTERN_PORT = 8'h0b;
  localparam logic [7:0] IDX_WAKE_CTL_STATUS = 8'h0c;
  localparam logic [7:0] IDX_RX_FRAME_STATUS = 8'h0e;
  // Field positions.
  localparam int BUSY_BIT = 0;
  localparam int PTR_CLEAR_BIT = 31;
  localparam int TAG_MSB = 15;
  // Reset values.
  localparam logic [15:0] TAG_RESET = 16'h0000;
  localparam logic [31:0] PAUSE_RESET = 32'h00000000;
  localparam logic [31:0] WAKE_RESET = 32'h00000000;
  // Frame length limits in bytes.
  localparam logic [10:0] MAX_LEN_PLAIN = 11'd1518;
  localparam logic [10:0] MAX_LEN_TAGGED = 11'd1522;
  // Wake filter geometry.
  localparam int WAKE_WORDS = 8;
  localparam int WAKE_PTR_W = 3;

  // Receive frame descriptor presented at end of frame.
  typedef struct packed {
    logic done;
    logic [15:0] typeBytes;
    logic [10:0] length;
  } mvw_rx_frame_t;

  // Result of the length check.
  typedef struct packed {
    logic valid;
    logic taggedA;
    logic taggedB;
    logic tooLong;
  } mvw_rx_result_t;
endpackage
`default_nettype wire

/* hw/mvw_regs.sv */
// How it works
// - Busy flag high during pause or backpressure.
// - Busy holds for frame, clears afterwards.
// - Tag ident A compared with bytes 13-14.
// - Tag ident B compared with same bytes.
// - Tagged frames allow 1522, else 1518.
// - Filter writes load consecutive words from zero.
// - Write pointer wraps after eight words.
// - Filter reads return words in sequence.
// - Pointer-reset control resynchronizes filter pointers.
// - Writing one resets pointers, bit self-clears.
//
// The Wishbone slave port was chosen for this implementation.
`default_nettype none
module mvw_regs
  import mvw_pkg::*;
(
  input wire logic sys_clk,
  input wire logic resetn,
  // Classic Wishbone slave.
  input wire logic wbCyc,
  input wire logic wbStb,
  input wire logic wbWe,
  input wire logic [7:0] wbAdr,
  input wire logic [3:0] wbSel,
  input wire logic [31:0] wbDatW,
  output logic [31:0] wbDatR,
  output logic wbAck,
  // Transmitter reports pause frame or backpressure activity.
  input wire logic pauseTxActive,
  // Pause control word for the flow-control logic outside.
  output logic [31:0] pauseControl,
  // Receive side.
  input wire mvw_rx_frame_t rxFrame,
  output mvw_rx_result_t rxResult,
  // Wake filter contents for the matcher.
  output logic [WAKE_WORDS*32-1:0] wakePatternWords
);

  typedef enum logic [1:0] {ST_IDLE, ST_ACK} mvw_bus_state_t;

  mvw_bus_state_t busState;
  mvw_bus_state_t next_busState;
  logic [15:0] tagIdentA;
  logic [15:0] tagIdentB;
  logic pauseTxBusyFlag;
  logic [31:0] pauseWord;
  logic [31:0] wakePatternStore [WAKE_WORDS];
  logic [WAKE_PTR_W-1:0] wakeWrPtr;
  logic [WAKE_PTR_W-1:0] wakeRdPtr;
  logic [31:0] readMux;
  logic matchA;
  logic matchB;
  mvw_rx_result_t next_rxResult;

  // Decode. A request is taken while the slave is idle, and a write lands at the
  // edge where the master samples ack, with the request still held.
  // A master that drops its strobe in the ack cycle therefore writes nothing.
  // Read data is registered at the taking edge so that it stands with ack.
  wire logic request = wbCyc && wbStb;
  wire logic accept = request && (busState == ST_IDLE);
  wire logic commit = request && (busState == ST_ACK);
  wire logic doWrite = commit && wbWe;
  wire logic doRead = accept && !wbWe;
  wire logic hitPause = (wbAdr == IDX_PAUSE_CONTROL);
  wire logic hitTagA = (wbAdr == IDX_TAG_MATCH_A);
  wire logic hitTagB = (wbAdr == IDX_TAG_MATCH_B);
  wire logic hitWake = (wbAdr == IDX_WAKE_PATTERN_PORT);
  wire logic hitWakeCtl = (wbAdr == IDX_WAKE_CTL_STATUS);
  wire logic hitRxStat = (wbAdr == IDX_RX_FRAME_STATUS);
  wire logic [31:0] byteMask = {{8{wbSel[3]}}, {8{wbSel[2]}}, {8{wbSel[1]}}, {8{wbSel[0]}}};
  wire logic [31:0] wakeWriteData = (wakePatternStore[wakeWrPtr] & ~byteMask)
                                   | (wbDatW & byteMask);
  // Pointer clear is a strobe; the stored bit is never held so it reads as zero.
  wire logic ptrClear = doWrite && hitWakeCtl && wbSel[3] && wbDatW[PTR_CLEAR_BIT];

  // Bus handshake: ack one cycle after the request, dropped the next cycle.
  // The state returns to idle after ack, so a strobe that is still held then
  // starts a new transfer; a classic master drops it for a cycle in between.
  always_comb
  begin
    next_busState = ST_IDLE;
    if (accept)
    begin
      next_busState = ST_ACK;
    end
  end

  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      busState <= ST_IDLE;
    end
    else
    begin
      busState <= next_busState;
    end
  end

  assign wbAck = (busState == ST_ACK);

  // Tag identifier registers; the upper half is reserved and reads zero. Both
  // identifiers behave alike, so each is one instance of the same small module,
  // which also compares its value with the type bytes of the current frame.
  mvw_tag_reg i_mvw_tag_reg_a (
    .sys_clk(sys_clk),
    .resetn(resetn),
    .writeEn(doWrite && hitTagA),
    .writeData(wbDatW[15:0]),
    .writeMask(byteMask[15:0]),
    .frameTag(rxFrame.typeBytes),
    .tagIdent(tagIdentA),
    .tagMatch(matchA)
  );

  mvw_tag_reg i_mvw_tag_reg_b (
    .sys_clk(sys_clk),
    .resetn(resetn),
    .writeEn(doWrite && hitTagB),
    .writeData(wbDatW[15:0]),
    .writeMask(byteMask[15:0]),
    .frameTag(rxFrame.typeBytes),
    .tagIdent(tagIdentB),
    .tagMatch(matchB)
  );

  // Pause control word; bit 0 is the hardware busy flag, software's value there is
  // never shown because a host is required to write zero and must not fake busy.
  // The stored word keeps whatever the host wrote in bit 0, but the read value
  // and the output always show the live flag there instead.
  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      pauseWord <= PAUSE_RESET;
    end
    else if (doWrite && hitPause)
    begin
      pauseWord <= (pauseWord & ~byteMask) | (wbDatW & byteMask);
    end
  end

  // Busy follows the transmitter: high while a pause frame or backpressure is
  // sent, low again once the control frame is complete.
  // A one-cycle lag behind the transmitter is accepted; it keeps the flag a
  // clean flip-flop output for the host and for the flow-control logic.
  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      pauseTxBusyFlag <= 1'b0;
    end
    else
    begin
      pauseTxBusyFlag <= pauseTxActive;
    end
  end

  always_comb
  begin
    pauseControl = pauseWord;
    pauseControl[BUSY_BIT] = pauseTxBusyFlag;
  end

  // Wake filter store: eight words, one pointer each way, both stepping per
  // access and wrapping naturally at the pointer width.
  // The store has no reset: the host must load all eight words before the
  // matcher may rely on them.
  always_ff @(posedge sys_clk)
  begin
    if (doWrite && hitWake)
    begin
      wakePatternStore[wakeWrPtr] <= wakeWriteData;
    end
  end

  // One pointer for each direction; a clear from the control register returns
  // both to the first word. Software that stops in the middle of a run of eight
  // uses that clear to find its place again.
  mvw_wrap_ptr i_mvw_wrap_ptr_wr (
    .sys_clk(sys_clk),
    .resetn(resetn),
    .clear(ptrClear),
    .step(doWrite && hitWake),
    .ptr(wakeWrPtr)
  );

  mvw_wrap_ptr i_mvw_wrap_ptr_rd (
    .sys_clk(sys_clk),
    .resetn(resetn),
    .clear(ptrClear),
    .step(doRead && hitWake),
    .ptr(wakeRdPtr)
  );

  // Flatten the store for the wake-up matcher.
  // The matcher sees every word at once and never goes through the access
  // port, so host reads cannot disturb matching.
  genvar gi;
  generate
    for (gi = 0; gi < WAKE_WORDS; gi++)
    begin : gen_flat
      assign wakePatternWords[gi*32 +: 32] = wakePatternStore[gi];
    end
  endgenerate

  // Read selection; unmapped addresses read zero and are still acknowledged.
  // Acknowledging everything keeps a stray host access from hanging the bus.
  // The wake control index reads zero because its only bit is a strobe.
  // The receive verdict sits in the low four bits of its status index.
  assign readMux = hitPause ? pauseControl :
                   hitTagA ? {16'h0000, tagIdentA} :
                   hitTagB ? {16'h0000, tagIdentB} :
                   hitWake ? wakePatternStore[wakeRdPtr] :
                   hitWakeCtl ? WAKE_RESET :
                   hitRxStat ? {28'h0000000, rxResult} :
                   32'h00000000;

  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      wbDatR <= 32'h00000000;
    end
    else if (doRead)
    begin
      wbDatR <= readMux;
    end
  end

  // Length check of a completed frame against its tag-dependent limit.
  wire logic isTagged = matchA || matchB;
  wire logic [10:0] lengthLimit = isTagged ? MAX_LEN_TAGGED : MAX_LEN_PLAIN;

  always_comb
  begin
    next_rxResult = rxResult;
    next_rxResult.valid = 1'b0;
    if (rxFrame.done)
    begin
      next_rxResult.valid = 1'b1;
      next_rxResult.taggedA = matchA;
      next_rxResult.taggedB = matchB;
      next_rxResult.tooLong = (rxFrame.length > lengthLimit);
    end
  end

  // The result stays readable until the next frame; valid pulses once.
  // Holding the verdict lets the host read it through the status index after
  // the pulse has gone.
  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      rxResult <= '0;
    end
    else
    begin
      rxResult <= next_rxResult;
    end
  end

endmodule

// One tag identifier register with its own frame comparison. The register
// honours byte enables; lanes that are not enabled keep their contents.
// The comparison is purely combinational and is sampled with the frame end.
module mvw_tag_reg
  import mvw_pkg::*;
(
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic writeEn,
  input wire logic [15:0] writeData,
  input wire logic [15:0] writeMask,
  input wire logic [15:0] frameTag,
  output logic [15:0] tagIdent,
  output logic tagMatch
);

  // Merge the enabled byte lanes of the host data with the old value.
  // The two masked halves are disjoint, so a plain or is enough.
  wire logic [15:0] next_tagIdent = (tagIdent & ~writeMask) | (writeData & writeMask);

  // The register itself.
  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      tagIdent <= TAG_RESET;
    end
    else if (writeEn)
    begin
      tagIdent <= next_tagIdent;
    end
  end

  // Compared with the two type bytes that follow the addresses of the frame.
  // A register left at zero matches only a frame whose type bytes are zero.
  assign tagMatch = (frameTag == tagIdent[TAG_MSB:0]);

endmodule

// A wrapping word pointer for the wake filter. It steps once per access and
// returns to the first word on a clear, which wins over a step in the same
// cycle so that software always finds the pointer at the start afterwards.
module mvw_wrap_ptr
  import mvw_pkg::*;
(
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic clear,
  input wire logic step,
  output logic [WAKE_PTR_W-1:0] ptr
);

  // The pointer width matches the store depth, so the carry out is the wrap.
  // This only holds while the depth stays a power of two.
  wire logic [WAKE_PTR_W-1:0] next_ptr = ptr + WAKE_PTR_W'(1);

  // Clear first, then step; reset puts the pointer at the first word.
  // The host therefore starts every run at word zero after either event.
  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      ptr <= '0;
    end
    else if (clear)
    begin
      ptr <= '0;
    end
    else if (step)
    begin
      ptr <= next_ptr;
    end
  end

endmodule
`default_nettype wire

/* test/mvw_assertions.sv */
`default_nettype none
module mvw_assertions
  import mvw_pkg::*;
(
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic wbCyc,
  input wire logic wbStb,
  input wire logic wbAck,
  input wire logic pauseTxActive,
  input wire logic [31:0] pauseControl,
  input wire mvw_rx_frame_t rxFrame,
  input wire mvw_rx_result_t rxResult
);
  timeunit 1ns;
  timeprecision 1ps;
  // One clock domain, so the clock and the reset muting are declared once.
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!resetn);
  // Bus answers come one cycle after the request and last one cycle.
  ack_after_req_a:
    assert property (wbCyc && wbStb && !wbAck |=> wbAck) else $error("no ack");
  ack_single_a:
    assert property (wbAck |=> !wbAck) else $error("ack held");
  // The busy flag trails the transmitter by one cycle.
  busy_rise_a:
    assert property ($rose(pauseTxActive) |=> pauseControl[0]) else $error("busy low");
  busy_stay_a:
    assert property (pauseTxActive [*3] |=> pauseControl[0]) else $error("busy drop");
  busy_clear_a:
    assert property ($fell(pauseTxActive) |=> !pauseControl[0]) else $error("busy stuck");
  // Length verdicts follow each frame end by one cycle.
  rx_answer_a:
    assert property (rxFrame.done |=> rxResult.valid) else $error("no result");
  long_frame_a:
    assert property (rxFrame.done && rxFrame.length > 11'd1522 |=> rxResult.tooLong)
      else $error("long passed");
  tag_limit_a:
    assert property (rxFrame.done && rxFrame.length inside {[1519:1522]}
      |=> rxResult.tooLong != (rxResult.taggedA || rxResult.taggedB)) else $error("bad limit");
endmodule
bind mvw_regs mvw_assertions i_mvw_assertions (.sys_clk(sys_clk), .resetn(resetn),
  .wbCyc(wbCyc), .wbStb(wbStb), .wbAck(wbAck), .pauseTxActive(pauseTxActive),
  .pauseControl(pauseControl), .rxFrame(rxFrame), .rxResult(rxResult));
`default_nettype wire

/* test/mvw_net_model.sv */
`default_nettype none
module mvw_net_model
  import mvw_pkg::*;
(
  input wire logic sys_clk,
  output var mvw_rx_frame_t rxFrame,
  output var logic pauseTxActive
);
  timeunit 1ns;
  timeprecision 1ps;
  // Line starts idle with junk fields.
  initial
  begin
    rxFrame = '{1'b0, 16'hffff, 11'h7ff};
    pauseTxActive = 1'b0;
  end
  // Ends a frame after a random gap; fields are scrambled after so stale values never match.
  task automatic send(input logic [15:0] typ, input logic [10:0] len);
    repeat ($urandom_range(1, 4)) @(posedge sys_clk);
    rxFrame <= '{1'b1, typ, len};
    @(posedge sys_clk);
    rxFrame <= '{1'b0, ~typ, ~len};
  endtask
  // Keeps the transmitter busy for a whole pause frame.
  task automatic pause(input int n);
    @(posedge sys_clk);
    pauseTxActive <= 1'b1;
    repeat (n) @(posedge sys_clk);
    pauseTxActive <= 1'b0;
  endtask
endmodule
`default_nettype wire

/* test/testbench.sv */
`default_nettype none
module testbench
  import mvw_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic sys_clk, resetn, wbCyc, wbStb, wbWe, wbAck, pauseTxActive, a, b;
  logic [7:0] wbAdr;
  logic [3:0] wbSel;
  logic [31:0] wbDatW, wbDatR, pauseControl, pw;
  logic [31:0] rdQ[$], w[8];
  logic [255:0] wakeWords;
  mvw_rx_frame_t rxFrame;
  mvw_rx_result_t rxResult;
  mvw_rx_result_t rxQ[$];
  logic [15:0] tagA, tagB;
  logic [10:0] lens[4] = '{11'd1518, 11'd1519, 11'd1522, 11'd1523};
  int fail_count, samples_checked;
  mvw_regs i_mvw_regs (.sys_clk(sys_clk), .resetn(resetn), .wbCyc(wbCyc), .wbStb(wbStb),
    .wbWe(wbWe), .wbAdr(wbAdr), .wbSel(wbSel), .wbDatW(wbDatW), .wbDatR(wbDatR),
    .wbAck(wbAck), .pauseTxActive(pauseTxActive), .pauseControl(pauseControl),
    .rxFrame(rxFrame), .rxResult(rxResult), .wakePatternWords(wakeWords));
  mvw_net_model i_mvw_net_model (.sys_clk(sys_clk), .rxFrame(rxFrame),
    .pauseTxActive(pauseTxActive));
  // Free-running 4 ns clock.
  initial
  begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end
  task automatic end_of_test();
    $display("checked %0d, mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic cmpRd(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin fail_count++; $display("[FAIL] %0t read %h not %h", $time, got, exp); end
  endtask
  task automatic cmpRx(input mvw_rx_result_t got, input mvw_rx_result_t exp);
    samples_checked++;
    if (got !== exp) begin fail_count++; $display("[FAIL] %0t rx %b not %b", $time, got, exp); end
  endtask
  // The oldest note is matched against each result as it appears.
  always @(posedge sys_clk)
  begin
    if (wbAck === 1'b1 && wbWe === 1'b0) cmpRd(wbDatR, rdQ.pop_front());
    if (rxResult.valid === 1'b1) cmpRx(rxResult, rxQ.pop_front());
  end
  // Classic cycle: hold everything until ack is sampled, then release for a cycle.
  task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] d);
    @(posedge sys_clk);
    {wbCyc, wbStb, wbWe, wbAdr, wbDatW} <= {2'b11, we, adr, d};
    do @(posedge sys_clk); while (wbAck !== 1'b1);
    {wbCyc, wbStb} <= 2'b00;
  endtask
  task automatic rd(input logic [7:0] adr, input logic [31:0] exp);
    rdQ.push_back(exp);
    wb(1'b0, adr, 32'h0);
  endtask
  task automatic frm(input logic [15:0] t, input logic [10:0] l);
    a = (t == tagA);
    b = (t == tagB);
    rxQ.push_back('{1'b1, a, b, l > ((a | b) ? MAX_LEN_TAGGED : MAX_LEN_PLAIN)});
    i_mvw_net_model.send(t, l);
  endtask
  // Watchdog well beyond the few hundred cycles the tests need.
  initial
  begin
    repeat (20000) @(posedge sys_clk);
    fail_count++;
    end_of_test();
  end
  initial
  begin
    {resetn, wbCyc, wbStb, wbWe, wbAdr, wbDatW, wbSel} = {1'b0, 43'h0, 4'hf};
    fail_count = 0;
    samples_checked = 0;
    void'($urandom(90540));
    repeat (12) @(posedge sys_clk);
    resetn <= 1'b1;
    rd(IDX_TAG_MATCH_A, 32'h0);
    rd(IDX_TAG_MATCH_B, 32'h0);
    rd(8'h3f, 32'h0);
    $display("reset values done");
    // Only one identifier is in use at a time, and it holds the standard tag value.
    for (int k = 0; k < 2; k++)
    begin
      {tagA, tagB} = k ? 32'h00008100 : 32'h81000000;
      wb(1'b1, IDX_TAG_MATCH_A, {16'hffff, tagA});
      wb(1'b1, IDX_TAG_MATCH_B, {16'hffff, tagB});
      rd(IDX_TAG_MATCH_B, {16'h0, tagB});
      foreach (lens[j]) frm(16'h8100, lens[j]);
      foreach (lens[j]) frm(16'($urandom_range(1, 16'h80ff)), lens[j]);
    end
    wbSel <= 4'h2;
    wb(1'b1, IDX_TAG_MATCH_A, 32'h1234abcd);
    wbSel <= 4'hf;
    rd(IDX_TAG_MATCH_A, 32'h0000ab00);
    $display("tag frames done");
    foreach (w[i]) w[i] = $urandom;
    foreach (w[i]) wb(1'b1, IDX_WAKE_PATTERN_PORT, w[i]);
    for (int i = 0; i < 3; i++) w[i] = $urandom;
    for (int i = 0; i < 3; i++) wb(1'b1, IDX_WAKE_PATTERN_PORT, w[i]);
    @(posedge sys_clk);
    foreach (w[i]) cmpRd(wakeWords[i*32 +: 32], w[i]);
    foreach (w[i]) rd(IDX_WAKE_PATTERN_PORT, w[i]);
    for (int i = 0; i < 3; i++) rd(IDX_WAKE_PATTERN_PORT, w[i]);
    wb(1'b1, IDX_WAKE_CTL_STATUS, 32'h80000000);
    rd(IDX_WAKE_PATTERN_PORT, w[0]);
    w[0] = $urandom;
    wb(1'b1, IDX_WAKE_PATTERN_PORT, w[0]);
    wb(1'b1, IDX_WAKE_CTL_STATUS, 32'h80000000);
    rd(IDX_WAKE_CTL_STATUS, 32'h0);
    foreach (w[i]) rd(IDX_WAKE_PATTERN_PORT, w[i]);
    $display("wake filter done");
    resetn <= 1'b0;
    repeat (2) @(posedge sys_clk);
    resetn <= 1'b1;
    rd(IDX_TAG_MATCH_A, 32'h0);
    rd(IDX_WAKE_PATTERN_PORT, w[0]);
    $display("mid-run reset done");
    rd(IDX_PAUSE_CONTROL, 32'h0);
    pw = $urandom & 32'hfffffffe;
    wb(1'b1, IDX_PAUSE_CONTROL, pw);
    fork
      i_mvw_net_model.pause(20);
      begin repeat (3) @(posedge sys_clk); rd(IDX_PAUSE_CONTROL, pw | 32'h1); end
    join
    repeat (2) @(posedge sys_clk);
    rd(IDX_PAUSE_CONTROL, pw);
    repeat (3) @(posedge sys_clk);
    $display("busy flag done");
    end_of_test();
  end
endmodule
`default_nettype wire
